// File: pic_pkg.sv
package pic_pkg;
  // ---------------------------------------------------------------
  // Sizes of the controller
  // ---------------------------------------------------------------
  localparam int NUM_SRC     = 128; // All sources, software ones first
  localparam int NUM_SW      = 8;   // Software-settable sources 0..7
  localparam int NUM_CPU     = 2;   // Processors that may set them
  localparam int PRIO_W      = 4;   // 16 priority levels
  localparam int VEC_W       = 9;   // Vector width to the core
  localparam int SRC_W       = 7;   // Source index width
  localparam int STACK_DEPTH = 16;  // Nesting depth of saved priorities

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_RST     = 4'h0;
  localparam logic [PRIO_W-1:0] CUR_PRIO_RST = 4'h0;
  localparam logic [VEC_W-1:0]  VEC_RST      = 9'h000;
endpackage

// File: pic_prio_stack.sv
`timescale 1ns/1ns
// LIFO of preempted priorities; top of stack comes out of a register
module pic_prio_stack
  import pic_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic              push_in,
  input  wire logic              pop_in,
  input  wire logic [PRIO_W-1:0] push_data_in,
  output logic      [PRIO_W-1:0] top_out,
  output logic                   empty_out,
  output logic                   full_out
);
  localparam int PW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);

  logic [PRIO_W-1:0] mem_r [DEPTH];
  logic [PW-1:0]     sp_r;
  logic [PRIO_W-1:0] top_r;

  assign empty_out = (sp_r == '0);
  assign full_out  = (sp_r == PW'(DEPTH));
  assign top_out   = top_r;

  // Storage; push is ignored when full, pop when empty
  always_ff @(posedge sys_clk_in) begin
    if (push_in && !full_out) begin
      mem_r[sp_r[AW-1:0]] <= push_data_in;
    end
  end

  // Pointer and registered top
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sp_r  <= '0;
      top_r <= PRIO_RST;
    end else if (push_in && !full_out) begin
      sp_r  <= sp_r + PW'(1);
      top_r <= push_data_in;
    end else if (pop_in && !empty_out) begin
      sp_r  <= sp_r - PW'(1);
      top_r <= (sp_r >= PW'(2)) ? mem_r[AW'(sp_r - PW'(2))] : PRIO_RST;
    end
  end
endmodule // pic_prio_stack

// File: pic_priority_irq_unit.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Up to 128 sources; dispatched source named by a distinct 9-bit vector.
// - Every source has its own software-written priority for arbitration.
// - Sixteen levels; equal-level ties go to the lowest source index.
// - A request above the running routine's priority is sent at once.
// - Writable current priority blocks requests at or below it.
// - Eight software-set sources are arbitrated and vectored like peripherals.
// - Non-maskable request goes straight to the core, untouched.
// - Several processors may each set the software requests.
module pic_priority_irq_unit
  import pic_pkg::*;
#(
  parameter int N_CPU = NUM_CPU
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_in,
  input  wire logic [NUM_SRC-1:NUM_SW]   periph_irq_in,
  input  wire logic [N_CPU*NUM_SW-1:0]   sw_set_in,
  input  wire logic [N_CPU*NUM_SW-1:0]   sw_clr_in,
  input  wire logic                      prio_wr_en_in,
  input  wire logic [SRC_W-1:0]          prio_wr_idx_in,
  input  wire logic [PRIO_W-1:0]         prio_wr_val_in,
  input  wire logic                      cur_prio_wr_en_in,
  input  wire logic [PRIO_W-1:0]         cur_prio_wr_val_in,
  input  wire logic                      irq_ack_in,
  input  wire logic                      irq_end_in,
  input  wire logic                      nmi_in,
  output logic                           irq_req_out,
  output logic      [VEC_W-1:0]          irq_vec_out,
  output logic      [PRIO_W-1:0]         irq_prio_out,
  output logic      [PRIO_W-1:0]         cur_prio_out,
  output logic      [NUM_SW-1:0]         sw_pend_out,
  output logic                           nmi_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [PRIO_W-1:0]  prio_r [NUM_SRC];
  logic [NUM_SW-1:0]  sw_pend_r;
  logic [NUM_SW-1:0]  sw_set_any;
  logic [NUM_SW-1:0]  sw_clr_any;
  logic [NUM_SRC-1:0] pending;
  logic [PRIO_W-1:0]  cur_prio_r;
  logic [PRIO_W-1:0]  cur_prio_nxt;
  logic               irq_req_r;
  logic [VEC_W-1:0]   irq_vec_r;
  logic [PRIO_W-1:0]  irq_prio_r;
  logic [SRC_W-1:0]   best_idx;
  logic [PRIO_W-1:0]  best_prio;
  logic               best_valid;
  logic               take_ack;
  logic               take_end;
  logic [PRIO_W-1:0]  stk_top;
  logic               stk_empty;

  // ---------------------------------------------------------------
  // Software-settable requests
  // ---------------------------------------------------------------
  // Merge the set and clear strobes of all processors
  always_comb begin
    sw_set_any = '0;
    sw_clr_any = '0;
    for (int c = 0; c < N_CPU; c++) begin
      sw_set_any |= sw_set_in[c*NUM_SW +: NUM_SW];
      sw_clr_any |= sw_clr_in[c*NUM_SW +: NUM_SW];
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_pend_r <= '0;
    end else begin
      sw_pend_r <= (sw_pend_r & ~sw_clr_any) | sw_set_any;
    end
  end

  assign pending     = {periph_irq_in, sw_pend_r};
  assign sw_pend_out = sw_pend_r;

  // ---------------------------------------------------------------
  // Per-source priorities
  // ---------------------------------------------------------------
  // Software writes one source's level at a time
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        prio_r[i] <= PRIO_RST;
      end
    end else if (prio_wr_en_in) begin
      prio_r[prio_wr_idx_in] <= prio_wr_val_in;
    end
  end

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  // Highest level wins; strict compare keeps the lowest index on ties
  always_comb begin
    best_idx   = '0;
    best_prio  = '0;
    best_valid = 1'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pending[i] && (!best_valid || prio_r[i] > best_prio)) begin
        best_idx   = SRC_W'(i);
        best_prio  = prio_r[i];
        best_valid = 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Current priority and nesting
  // ---------------------------------------------------------------
  assign take_ack = irq_ack_in && irq_req_r;
  assign take_end = irq_end_in && !take_ack && !stk_empty;

  // Acknowledge first, then end of routine, then a software write
  always_comb begin
    cur_prio_nxt = cur_prio_r;
    if (take_ack) begin
      cur_prio_nxt = irq_prio_r;
    end else if (take_end) begin
      cur_prio_nxt = stk_top;
    end else if (cur_prio_wr_en_in) begin
      cur_prio_nxt = cur_prio_wr_val_in;
    end
  end

  // Current priority register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_prio_r <= CUR_PRIO_RST;
    end else begin
      cur_prio_r <= cur_prio_nxt;
    end
  end

  // Saved priorities of preempted routines
  pic_prio_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .push_in      (take_ack),
    .pop_in       (take_end),
    .push_data_in (cur_prio_r),
    .top_out      (stk_top),
    .empty_out    (stk_empty),
    .full_out     ()
  );

  // ---------------------------------------------------------------
  // Request to the core
  // ---------------------------------------------------------------
  // Judged against the next current priority so an ack never repeats
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_req_r  <= 1'h0;
      irq_vec_r  <= VEC_RST;
      irq_prio_r <= PRIO_RST;
    end else begin
      irq_req_r  <= best_valid && (best_prio > cur_prio_nxt);
      irq_vec_r  <= VEC_W'(best_idx);
      irq_prio_r <= best_prio;
    end
  end

  assign irq_req_out  = irq_req_r;
  assign irq_vec_out  = irq_vec_r;
  assign irq_prio_out = irq_prio_r;
  assign cur_prio_out = cur_prio_r;
  assign nmi_out      = nmi_in;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] pend_q;
  logic               tie_ok;

  // Pending set seen by the last arbitration
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q <= '0;
    end else begin
      pend_q <= pending;
    end
  end

  // No lower index at an equal or higher level was pending
  always_comb begin
    tie_ok = 1'h1;
    for (int j = 0; j < NUM_SRC; j++) begin
      if (SRC_W'(j) < irq_vec_r[SRC_W-1:0] && pend_q[j] && prio_r[j] >= irq_prio_r) begin
        tie_ok = 1'h0;
      end
    end
  end

  a_req_above_mask: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_req_r |-> irq_prio_r > cur_prio_r) else $error("request not above current priority");

  a_vec_names_src: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_req_r |-> (irq_vec_r[VEC_W-1:SRC_W] == '0) && pend_q[irq_vec_r[SRC_W-1:0]])
    else $error("vector does not name a pending source");

  a_tie_low_index: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_req_r && !$past(prio_wr_en_in) |-> tie_ok) else $error("tie not won by lowest index");

  a_prio_stored: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    prio_wr_en_in |=> prio_r[$past(prio_wr_idx_in)] == $past(prio_wr_val_in))
    else $error("priority write lost");

  a_preempt_sent: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    best_valid && best_prio > cur_prio_nxt |=> irq_req_r) else $error("preempting request not sent");

  a_ack_raises: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_ack_in && irq_req_r |=> cur_prio_r == $past(irq_prio_r) ##1 !irq_req_r || irq_prio_r > cur_prio_r)
    else $error("acknowledge did not raise priority");

  a_end_restores: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_end_in && !take_ack && !stk_empty |=> cur_prio_r == $past(stk_top))
    else $error("end of routine did not restore priority");

  a_sw_set_wins: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sw_set_any[0] |=> sw_pend_r[0] ##1 (sw_pend_r[0] || $past(sw_clr_any[0] && !sw_set_any[0])))
    else $error("software request lost");

  a_nmi_direct: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    nmi_out == nmi_in) else $error("non-maskable path altered");
endmodule // pic_priority_irq_unit

// File: pic_core_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Core model: accepts shown requests
// ----------------------------------------
module pic_core_model
  import pic_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic              ack_en_in,
  input  wire logic [PRIO_W-1:0] ack_dly_in,
  input  wire logic              irq_req_in,
  input  wire logic [VEC_W-1:0]  irq_vec_in,
  output logic                   irq_ack_out,
  output logic      [VEC_W-1:0]  vec_seen_out
);
  logic [PRIO_W-1:0] wait_r;

  // One acknowledge pulse per shown request, promptly or after a wait
  always @(negedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_ack_out <= 1'h0;
      wait_r      <= 4'h0;
    end else if (irq_ack_out) begin
      irq_ack_out <= 1'h0;
    end else if (ack_en_in && irq_req_in) begin
      if (wait_r >= ack_dly_in) begin
        irq_ack_out <= 1'h1;
        wait_r      <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      wait_r <= 4'h0;
    end
  end

  // Remember the vector taken with the acknowledge
  always @(posedge sys_clk_in) begin
    if (irq_ack_out && irq_req_in) begin
      vec_seen_out <= irq_vec_in;
    end
  end
endmodule // pic_core_model

// File: pic_tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the priority interrupt unit
// ----------------------------------------
module testbench;
  import pic_pkg::*;
  logic                      sys_clk_in, rst_in, prio_wr_en_in, cur_prio_wr_en_in, irq_end_in, nmi_in;
  logic                      ack_en, irq_req_out, irq_ack_in, nmi_out;
  logic [NUM_SRC-1:NUM_SW]   periph_irq_in;
  logic [NUM_CPU*NUM_SW-1:0] sw_set_in, sw_clr_in;
  logic [SRC_W-1:0]          prio_wr_idx_in;
  logic [PRIO_W-1:0]         prio_wr_val_in, cur_prio_wr_val_in, irq_prio_out, cur_prio_out, ack_dly;
  logic [VEC_W-1:0]          irq_vec_out, vec_seen;
  logic [NUM_SW-1:0]         sw_pend_out;
  int                        fail_count, check_count;

  // System clock
  initial begin
    sys_clk_in = 1'h0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  pic_priority_irq_unit uut (.sys_clk_in, .rst_in, .periph_irq_in, .sw_set_in, .sw_clr_in, .prio_wr_en_in,
    .prio_wr_idx_in, .prio_wr_val_in, .cur_prio_wr_en_in, .cur_prio_wr_val_in, .irq_ack_in, .irq_end_in,
    .nmi_in, .irq_req_out, .irq_vec_out, .irq_prio_out, .cur_prio_out, .sw_pend_out, .nmi_out);
  pic_core_model core (.sys_clk_in, .rst_in, .ack_en_in(ack_en), .ack_dly_in(ack_dly),
    .irq_req_in(irq_req_out), .irq_vec_in(irq_vec_out), .irq_ack_out(irq_ack_in), .vec_seen_out(vec_seen));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait for the request line
  task automatic wait_req(input logic lvl);
    for (int i = 0; i < 20 && irq_req_out !== lvl; i++) cyc(1);
    chk("irq_req", {8'h00, lvl}, {8'h00, irq_req_out});
    if (irq_req_out !== lvl) final_report();
  endtask
  task automatic set_prio(input logic [6:0] idx, input logic [3:0] val);
    prio_wr_en_in = 1'h1;
    prio_wr_idx_in = idx;
    prio_wr_val_in = val;
    cyc(1);
    prio_wr_en_in = 1'h0;
    cyc(1);
  endtask
  task automatic set_cur(input logic [3:0] val);
    cur_prio_wr_en_in = 1'h1;
    cur_prio_wr_val_in = val;
    cyc(1);
    cur_prio_wr_en_in = 1'h0;
    cyc(1);
  endtask
  task automatic end_isr;
    irq_end_in = 1'h1;
    cyc(1);
    irq_end_in = 1'h0;
    cyc(2);
  endtask
  task automatic sw_pulse(input int bitn, input logic clr);
    if (clr) sw_clr_in[bitn] = 1'h1;
    else sw_set_in[bitn] = 1'h1;
    cyc(1);
    sw_set_in = '0;
    sw_clr_in = '0;
    cyc(2);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_vec;
    int src[3] = '{8, 20, 127};
    foreach (src[i]) begin
      set_prio(src[i][6:0], 4'h5);
      periph_irq_in[src[i]] = 1'h1;
      wait_req(1'h1);
      chk("vec", src[i][8:0], irq_vec_out);
      chk("prio", 9'h005, {5'h00, irq_prio_out});
      periph_irq_in[src[i]] = 1'h0;
      wait_req(1'h0);
    end
    $display("test vec done");
  endtask
  task automatic t_tie;
    set_prio(7'h1E, 4'h3);
    set_prio(7'h09, 4'h3);
    set_prio(7'h32, 4'h2);
    periph_irq_in[30] = 1'h1;
    periph_irq_in[50] = 1'h1;
    wait_req(1'h1);
    chk("vec", 9'h01E, irq_vec_out);
    periph_irq_in[9] = 1'h1;
    cyc(3);
    chk("vec", 9'h009, irq_vec_out);
    periph_irq_in = '0;
    wait_req(1'h0);
    $display("test tie done");
  endtask
  task automatic t_preempt;
    set_prio(7'h28, 4'h9);
    ack_dly = 4'h0;
    ack_en = 1'h1;
    periph_irq_in[20] = 1'h1;
    wait_req(1'h1);
    cyc(3);
    chk("cur", 9'h005, {5'h00, cur_prio_out});
    chk("taken", 9'h014, vec_seen);
    ack_dly = 4'h2;
    periph_irq_in[40] = 1'h1;
    wait_req(1'h1);
    chk("vec", 9'h028, irq_vec_out);
    cyc(6);
    chk("cur", 9'h009, {5'h00, cur_prio_out});
    ack_en = 1'h0;
    periph_irq_in[40] = 1'h0;
    end_isr;
    chk("cur", 9'h005, {5'h00, cur_prio_out});
    chk("req", 9'h000, {8'h00, irq_req_out});
    end_isr;
    chk("cur", 9'h000, {5'h00, cur_prio_out});
    wait_req(1'h1);
    chk("vec", 9'h014, irq_vec_out);
    periph_irq_in[20] = 1'h0;
    wait_req(1'h0);
    $display("test preempt done");
  endtask
  task automatic t_mask;
    set_cur(4'h5);
    chk("cur", 9'h005, {5'h00, cur_prio_out});
    set_prio(7'h3C, 4'h5);
    set_prio(7'h3D, 4'h6);
    periph_irq_in[60] = 1'h1;
    cyc(3);
    chk("req", 9'h000, {8'h00, irq_req_out});
    periph_irq_in[61] = 1'h1;
    wait_req(1'h1);
    chk("vec", 9'h03D, irq_vec_out);
    periph_irq_in = '0;
    set_cur(4'hF);
    nmi_in = 1'h1;
    cyc(1);
    chk("nmi", 9'h001, {8'h00, nmi_out});
    chk("req", 9'h000, {8'h00, irq_req_out});
    nmi_in = 1'h0;
    cyc(1);
    chk("nmi", 9'h000, {8'h00, nmi_out});
    set_cur(4'h0);
    $display("test mask done");
  endtask
  task automatic t_soft;
    for (int k = 0; k < NUM_SW; k++) begin
      set_prio(k[6:0], k[3:0] + 4'h1);
      sw_pulse((k % NUM_CPU) * NUM_SW + k, 1'h0);
      chk("pend", 9'(1 << k), {1'h0, sw_pend_out});
      wait_req(1'h1);
      chk("vec", k[8:0], irq_vec_out);
      sw_pulse((k % NUM_CPU) * NUM_SW + k, 1'h1);
      wait_req(1'h0);
    end
    set_prio(7'h46, 4'h7);
    periph_irq_in[70] = 1'h1;
    ack_en = 1'h1;
    wait_req(1'h1);
    cyc(3);
    ack_en = 1'h0;
    periph_irq_in[70] = 1'h0;
    sw_pulse(2, 1'h0);
    chk("req", 9'h000, {8'h00, irq_req_out});
    end_isr;
    wait_req(1'h1);
    chk("vec", 9'h002, irq_vec_out);
    sw_pulse(2, 1'h1);
    wait_req(1'h0);
    // Set from one processor and clear from the other in one cycle
    sw_set_in[3] = 1'h1;
    sw_clr_in[NUM_SW+3] = 1'h1;
    cyc(1);
    sw_set_in = '0;
    sw_clr_in = '0;
    cyc(1);
    chk("pend", 9'h008, {1'h0, sw_pend_out});
    sw_pulse(3, 1'h1);
    wait_req(1'h0);
    $display("test soft done");
  endtask
  task automatic t_reset;
    sw_pulse(5, 1'h0);
    set_cur(4'h3);
    rst_in = 1'h1;
    cyc(2);
    rst_in = 1'h0;
    cyc(1);
    chk("pend", 9'h000, {1'h0, sw_pend_out});
    chk("cur", 9'h000, {5'h00, cur_prio_out});
    chk("req", 9'h000, {8'h00, irq_req_out});
    $display("test reset done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    {rst_in, prio_wr_en_in, cur_prio_wr_en_in, irq_end_in, nmi_in, ack_en} = 6'h20;
    {periph_irq_in, sw_set_in, sw_clr_in, prio_wr_idx_in, prio_wr_val_in, cur_prio_wr_val_in, ack_dly} = '0;
    fail_count = 0;
    check_count = 0;
    cyc(10);
    rst_in = 1'h0;
    cyc(1);
    chk("cur", 9'h000, {5'h00, cur_prio_out});
    chk("pend", 9'h000, {1'h0, sw_pend_out});
    t_vec;
    t_tie;
    t_preempt;
    t_mask;
    t_soft;
    t_reset;
    final_report();
  end
endmodule // testbench
